// ### logic/rom_consts.svh
// Register offsets, field positions and reset values for the output mux block.
// Assumes inclusion by bare name from the output mux design file.
`ifndef ROM_CONSTS_SVH
`define ROM_CONSTS_SVH
`define ROM_OFF_OVERRIDE   8'h09
`define ROM_OFF_SDFORCE    8'h14
`define ROM_OFF_DIVSEL     8'h18
`define ROM_OFF_SRCSEL     8'h1E
`define ROM_OFF_RESEARCH   8'h3F
`define ROM_OVR_MUX_BIT    5
`define ROM_OVR_QCLK_BIT   4
`define ROM_OVR_DIV_BIT    2
`define ROM_SD_ON_BIT      7
`define ROM_SD_OFF_BIT     6
`define ROM_SRC_LSB        5
`define ROM_QCLK_EN_BIT    0
`define ROM_PRBS_EN_BIT    4
`define ROM_DIV_LSB        4
`define ROM_RESEARCH_BIT   7
`define ROM_RST_OVERRIDE   8'h00
`define ROM_RST_SDFORCE    8'h00
`define ROM_RST_DIVSEL     8'h00
`define ROM_RST_SRCSEL     8'hE0
`define ROM_RST_RESEARCH   8'h00
`define ROM_RST_RATIO      5'h01
`define ROM_DIV_MAX        3'h4
`define ROM_WORD_BITS      4
`endif

// ### logic/rom_pkg.sv
// Types shared by the output mux block.
// Assumes rom_consts.svh is on the include path.
package rom_pkg;
   typedef enum logic [2:0] {
      SRC_RAW    = 3'h0,
      SRC_RETIME = 3'h1,
      SRC_ICLK   = 3'h2,
      SRC_QCLK   = 3'h3,
      SRC_PRBS   = 3'h4,
      SRC_10MHZ  = 3'h5,
      SRC_BAD    = 3'h6,
      SRC_MUTE   = 3'h7
   } rom_src_t;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_WAIT  = 3'b010,
      ST_APPLY = 3'b100
   } rom_sw_state_t;

   // Register read or write request
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rom_reg_req_t;

   // Status seen by the channel
   typedef struct packed {
      logic       sig_det;
      logic       cdr_lock;
      logic [2:0] auto_div;
   } rom_chan_stat_t;
endpackage : rom_pkg

// ### logic/rom_sync.sv
// Three-stage synchroniser for one asynchronous level input.
// Assumes one clock; a change counts when stages two and three agree.
`timescale 1ns/1ps
module rom_sync (
   // Clock and reset
   input  wire logic clk,
   input  wire logic reset,
   // Data
   input  wire logic d,
   output logic      q
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic q;
   } rom_sync_state_t;

   rom_sync_state_t state_reg;
   rom_sync_state_t state_next;

   // Shift and agree
   always_comb begin
      state_next    = state_reg;
      state_next.s1 = d;
      state_next.s2 = state_reg.s1;
      state_next.s3 = state_reg.s2;
      if (state_reg.s2 == state_reg.s3) begin
         state_next.q = state_reg.s3;
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (reset) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign q = state_reg.q;
endmodule : rom_sync

// ### logic/rom_out_mux.sv
// Channel output source selection and oscillator divider override.
// Assumes a register master on the documented per-channel register port,
// with the channel already chosen; analog sources arrive as sampled levels.
// Every output leaves a flop; source changes wait for a serializer word edge.
// Detect and lock are asynchronous and pass four flops (three stages and the agreed output) before use.
//
// Notes on behaviour
// - No overrides: mute without signal or lock, retimed data once locked.
// - Source field sits in bits 7:5 at output_source_select, resets to mute.
// - Codes: 7 mute, 6 invalid, 5 10MHz, 4 PRBS, 3 Q, 2 I, 1 retimed, 0 raw.
// - PRBS source gives a sequence only while the generator is enabled.
// - Without override, the field governs only with signal but no lock.
// - With override set, the field always chooses the output; without signal detect the output still mutes.
// - Raw mode with re-search disable keeps the output from muting; this block only passes the bit out on research_disable.
// - No signal detected powers the channel down and mutes the output.
// - Bit 7 set, bit 6 clear at signal_detect_force forces signal detect on.
// - Both bits clear at signal_detect_force leaves detection to the circuit.
// - Without signal, retimed or raw selections give only noise or static level.
// - PRBS rate follows free-running oscillator, or the input when locked.
// - Internal 10 MHz clock selectable whenever override is active.
// - Locked: in-phase, quadrature and PRBS follow the input.
// - Automatic divider of 1, 2, 4, 8 or 16 in normal operation.
// - Bit 2 of override_enables takes the divider from bits 6:4 of vco_divider_select.
// - Divider codes 0 to 4 give ratios 1, 2, 4, 8, 16.
// - Override register resets to zero; writing zero clears overrides.
`timescale 1ns/1ps
`include "rom_consts.svh"
module rom_out_mux #(
   parameter int WORD_BITS = `ROM_WORD_BITS
) (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  reset,
   // Register port
   input  wire rom_pkg::rom_reg_req_t reg_req,
   output logic [7:0]                 reg_rdata,
   // Channel status, asynchronous
   input  wire logic                  sig_det_raw,
   input  wire logic                  cdr_lock_raw,
   input  wire logic [2:0]            auto_div,
   // Sampled sources
   input  wire logic                  raw_data,
   input  wire logic                  retimed_data,
   input  wire logic                  in_phase_oscillator_clock,
   input  wire logic                  quadrature_oscillator_clock,
   input  wire logic                  prbs_data,
   input  wire logic                  osc_10mhz,
   input  wire logic                  ser_tick,
   // Channel controls
   output logic                       ser_out,
   output logic                       out_driver_en,
   output logic                       chan_power_en,
   output logic                       prbs_enable,
   output logic                       qclk_enable,
   output logic                       research_disable,
   output logic [4:0]                 div_ratio,
   output logic [2:0]                 div_code,
   output logic [2:0]                 active_src
);
   //------------------------------------------------------------
   // State
   //------------------------------------------------------------
   typedef struct packed {
      // Registers as the master sees them
      logic [7:0]            ovr;
      logic [7:0]            sdf;
      logic [7:0]            div;
      logic [7:0]            src;
      logic [7:0]            rsr;
      // Read data, switch control and registered outputs
      logic [7:0]            rdata;
      rom_pkg::rom_sw_state_t sw;
      logic [$clog2(WORD_BITS)-1:0] bitcnt;
      logic [2:0]            cur_src;
      logic [2:0]            pend_src;
      logic [2:0]            div_eff;
      logic [4:0]            ratio;
      logic                  out;
      logic                  drv_en;
      logic                  pwr;
   } rom_state_t;

   rom_state_t state_reg;
   rom_state_t state_next;
   logic       sig_det_s;
   logic       lock_s;
   logic       sd_eff;
   logic [2:0] want_src;
   logic       src_bit;

   //------------------------------------------------------------
   // Input synchronisers
   //------------------------------------------------------------
   // One synchroniser each for detect and lock
   rom_sync u_sync_sd (
      .clk   (clk),
      .reset (reset),
      .d     (sig_det_raw),
      .q     (sig_det_s)
   );
   rom_sync u_sync_lock (
      .clk   (clk),
      .reset (reset),
      .d     (cdr_lock_raw),
      .q     (lock_s)
   );

   //------------------------------------------------------------
   // Source decision
   //------------------------------------------------------------
   always_comb begin
      // Forced detect or own circuit
      if (state_reg.sdf[`ROM_SD_ON_BIT] && !state_reg.sdf[`ROM_SD_OFF_BIT]) begin
         sd_eff = 1'b1;
      end else begin
         sd_eff = sig_det_s;
      end
      if (state_reg.ovr[`ROM_OVR_MUX_BIT]) begin
         want_src = state_reg.src[7:5];
      end else if (!sd_eff) begin
         want_src = rom_pkg::SRC_MUTE;
      end else if (lock_s) begin
         want_src = rom_pkg::SRC_RETIME;
      end else begin
         want_src = state_reg.src[7:5];
      end
      // Re-search muting lives outside; the disable bit is only passed on
   end

   // Serial bit from the active source
   always_comb begin
      case (state_reg.cur_src)
         rom_pkg::SRC_RAW:    src_bit = raw_data;
         rom_pkg::SRC_RETIME: src_bit = retimed_data;
         rom_pkg::SRC_ICLK:   src_bit = in_phase_oscillator_clock;
         rom_pkg::SRC_QCLK:   src_bit = quadrature_oscillator_clock
                                        & state_reg.ovr[`ROM_OVR_QCLK_BIT]
                                        & state_reg.src[`ROM_QCLK_EN_BIT];
         rom_pkg::SRC_PRBS:   src_bit = prbs_data
                                        & state_reg.src[`ROM_PRBS_EN_BIT];
         rom_pkg::SRC_10MHZ:  src_bit = osc_10mhz;
         default:             src_bit = 1'b0;
      endcase
   end

   //------------------------------------------------------------
   // Next state
   //------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      // Register writes
      if (reg_req.wr) begin
         case (reg_req.addr)
            `ROM_OFF_OVERRIDE: state_next.ovr = reg_req.wdata;
            `ROM_OFF_SDFORCE:  state_next.sdf = reg_req.wdata;
            `ROM_OFF_DIVSEL: begin
               if (reg_req.wdata[6:4] <= `ROM_DIV_MAX) begin
                  state_next.div = reg_req.wdata;
               end
            end
            `ROM_OFF_SRCSEL: begin
               if (reg_req.wdata[7:5] != rom_pkg::SRC_BAD) begin
                  state_next.src = reg_req.wdata;
               end
            end
            `ROM_OFF_RESEARCH: state_next.rsr = reg_req.wdata;
            default: ;
         endcase
      end
      // Register reads
      if (reg_req.rd) begin
         case (reg_req.addr)
            `ROM_OFF_OVERRIDE: state_next.rdata = state_reg.ovr;
            `ROM_OFF_SDFORCE:  state_next.rdata = state_reg.sdf;
            `ROM_OFF_DIVSEL:   state_next.rdata = state_reg.div;
            `ROM_OFF_SRCSEL:   state_next.rdata = state_reg.src;
            `ROM_OFF_RESEARCH: state_next.rdata = state_reg.rsr;
            default:           state_next.rdata = 8'h00;
         endcase
      end
      // Divider choice
      if (state_reg.ovr[`ROM_OVR_DIV_BIT]) begin
         state_next.div_eff = state_reg.div[6:4];
      end else if (auto_div <= `ROM_DIV_MAX) begin
         state_next.div_eff = auto_div;
      end
      // Ratio kept in a flop beside its code
      state_next.ratio = 5'h01 << state_next.div_eff;
      // Word counter on serializer ticks
      if (ser_tick) begin
         state_next.bitcnt = state_reg.bitcnt + 1'b1;
      end
      // Glitch-free switch at word boundary
      case (state_reg.sw)
         rom_pkg::ST_IDLE: begin
            if (want_src != state_reg.cur_src) begin
               state_next.pend_src = want_src;
               state_next.sw       = rom_pkg::ST_WAIT;
            end
         end
         rom_pkg::ST_WAIT: begin
            // Follow late changes so the latest choice is applied
            state_next.pend_src = want_src;
            if (ser_tick && state_reg.bitcnt == '1) begin
               state_next.sw = rom_pkg::ST_APPLY;
            end
         end
         rom_pkg::ST_APPLY: begin
            state_next.cur_src = state_reg.pend_src;
            state_next.sw      = rom_pkg::ST_IDLE;
         end
         default: state_next.sw = rom_pkg::ST_IDLE;
      endcase
      // Output and power
      if (ser_tick) begin
         state_next.out = src_bit;
      end
      state_next.pwr    = sd_eff;
      state_next.drv_en = sd_eff && (state_reg.cur_src != rom_pkg::SRC_MUTE);
      // Mute wins over the tick so a muted lane never toggles
      if (state_reg.cur_src == rom_pkg::SRC_MUTE || !sd_eff) begin
         state_next.out = 1'b0;
      end
   end

   //------------------------------------------------------------
   // State register
   //------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         // Source starts muted so nothing leaves before a decision
         state_reg          <= '0;
         state_reg.ovr      <= `ROM_RST_OVERRIDE;
         state_reg.sdf      <= `ROM_RST_SDFORCE;
         state_reg.div      <= `ROM_RST_DIVSEL;
         state_reg.src      <= `ROM_RST_SRCSEL;
         state_reg.rsr      <= `ROM_RST_RESEARCH;
         state_reg.sw       <= rom_pkg::ST_IDLE;
         state_reg.cur_src  <= rom_pkg::SRC_MUTE;
         state_reg.pend_src <= rom_pkg::SRC_MUTE;
         state_reg.ratio    <= `ROM_RST_RATIO;
      end else begin
         state_reg <= state_next;
      end
   end

   //------------------------------------------------------------
   // Outputs
   //------------------------------------------------------------
   assign reg_rdata        = state_reg.rdata;
   assign ser_out          = state_reg.out;
   assign out_driver_en    = state_reg.drv_en;
   assign chan_power_en    = state_reg.pwr;
   assign prbs_enable      = state_reg.src[`ROM_PRBS_EN_BIT];
   assign qclk_enable      = state_reg.ovr[`ROM_OVR_QCLK_BIT];
   assign research_disable = state_reg.rsr[`ROM_RESEARCH_BIT];
   assign div_code         = state_reg.div_eff;
   assign active_src       = state_reg.cur_src;
   // Divide ratio one-hot from code
   assign div_ratio        = state_reg.ratio;

   //------------------------------------------------------------
   // Checks
   //------------------------------------------------------------
   mute_no_signal_a: assert property (@(posedge clk) disable iff (reset)
      !sd_eff |=> !out_driver_en && !chan_power_en)
      else $error("Output not muted without signal");
   div_override_a: assert property (@(posedge clk) disable iff (reset)
      state_reg.ovr[`ROM_OVR_DIV_BIT] |=> div_code == $past(state_reg.div[6:4]))
      else $error("Divider override not applied");
   div_ratio_map_a: assert property (@(posedge clk) disable iff (reset)
      div_code <= 3'h4 && div_ratio == (5'h01 << div_code))
      else $error("Divider ratio mapping wrong");
   src_reset_mute_a: assert property (@(posedge clk)
      reset |=> state_reg.src[7:5] == 3'h7 && state_reg.ovr == 8'h00)
      else $error("Reset values wrong");
   src_reserved_a: assert property (@(posedge clk) disable iff (reset)
      state_reg.src[7:5] != 3'h6)
      else $error("Reserved source stored");
   lock_retime_a: assert property (@(posedge clk) disable iff (reset)
      (!state_reg.ovr[5] && sd_eff && lock_s) |-> want_src == 3'h1)
      else $error("Locked channel not retimed");
   unlocked_field_a: assert property (@(posedge clk) disable iff (reset)
      (!state_reg.ovr[5] && sd_eff && !lock_s) |-> want_src == state_reg.src[7:5])
      else $error("Unlocked field not used");
   override_field_a: assert property (@(posedge clk) disable iff (reset)
      state_reg.ovr[5] |-> want_src == state_reg.src[7:5])
      else $error("Override field not used");
   force_detect_a: assert property (@(posedge clk) disable iff (reset)
      (state_reg.sdf[7:6] == 2'b10) |=> chan_power_en)
      else $error("Forced detect not applied");
   switch_boundary_a: assert property (@(posedge clk) disable iff (reset)
      $changed(active_src) |-> $past(state_reg.sw) == rom_pkg::ST_APPLY)
      else $error("Source changed off word boundary");

   // Output path, divider and register checks
   mute_out_low_a: assert property (@(posedge clk) disable iff (reset)
      (state_reg.cur_src == rom_pkg::SRC_MUTE) |=> !ser_out)
      else $error("Muted output not low");
   mute_driver_off_a: assert property (@(posedge clk) disable iff (reset)
      (state_reg.cur_src == rom_pkg::SRC_MUTE) |=> !out_driver_en)
      else $error("Driver on while muted");
   driver_on_a: assert property (@(posedge clk) disable iff (reset)
      (sd_eff && state_reg.cur_src != rom_pkg::SRC_MUTE) |=> out_driver_en)
      else $error("Driver off for a live source");
   qclk_gate_a: assert property (@(posedge clk) disable iff (reset)
      (ser_tick && state_reg.cur_src == rom_pkg::SRC_QCLK
       && !(qclk_enable && state_reg.src[`ROM_QCLK_EN_BIT])) |=> !ser_out)
      else $error("Quadrature clock passed without enables");
   prbs_gate_a: assert property (@(posedge clk) disable iff (reset)
      (ser_tick && state_reg.cur_src == rom_pkg::SRC_PRBS && !prbs_enable) |=> !ser_out)
      else $error("PRBS passed without enable");
   retime_follow_a: assert property (@(posedge clk) disable iff (reset)
      (ser_tick && sd_eff && state_reg.cur_src == rom_pkg::SRC_RETIME)
      |=> ser_out == $past(retimed_data))
      else $error("Retimed bit not passed");
   iclk_follow_a: assert property (@(posedge clk) disable iff (reset)
      (ser_tick && sd_eff && state_reg.cur_src == rom_pkg::SRC_ICLK)
      |=> ser_out == $past(in_phase_oscillator_clock))
      else $error("In-phase clock not passed");
   osc_follow_a: assert property (@(posedge clk) disable iff (reset)
      (ser_tick && sd_eff && state_reg.cur_src == rom_pkg::SRC_10MHZ)
      |=> ser_out == $past(osc_10mhz))
      else $error("Internal clock not passed");
   div_stored_a: assert property (@(posedge clk) disable iff (reset)
      state_reg.div[6:4] <= `ROM_DIV_MAX)
      else $error("Reserved divider stored");
   auto_div_a: assert property (@(posedge clk) disable iff (reset)
      (!state_reg.ovr[`ROM_OVR_DIV_BIT] && auto_div <= `ROM_DIV_MAX) |=> div_code == $past(auto_div))
      else $error("Automatic divider not followed");
   override_clear_a: assert property (@(posedge clk) disable iff (reset)
      (reg_req.wr && reg_req.addr == `ROM_OFF_OVERRIDE && reg_req.wdata == 8'h00)
      |=> state_reg.ovr == 8'h00)
      else $error("Override register not cleared");
   own_detect_a: assert property (@(posedge clk) disable iff (reset)
      (state_reg.sdf[7:6] == 2'b00) |=> chan_power_en == $past(sig_det_s))
      else $error("Own detect not used");
   switch_apply_a: assert property (@(posedge clk) disable iff (reset)
      (state_reg.sw == rom_pkg::ST_APPLY) |=> active_src == $past(state_reg.pend_src))
      else $error("Pending source not applied");

   // Main scenarios
   prbs_cov_c: cover property (@(posedge clk) active_src == 3'h4 && prbs_enable);
   retime_cov_c: cover property (@(posedge clk) active_src == 3'h1);
   osc_cov_c: cover property (@(posedge clk) active_src == 3'h5);
   divovr_cov_c: cover property (@(posedge clk) state_reg.ovr[2] && div_code == 3'h4);
   raw_cov_c: cover property (@(posedge clk) active_src == 3'h0 && out_driver_en);
endmodule : rom_out_mux

// ### verif/rom_src_model.sv
// Upstream source model: sampled source levels and serializer bit ticks.
// Assumes the bench sets the levels and gates the ticks off when it wants.
`timescale 1ns/1ps
module rom_src_model (
   // Clock
   input  wire logic       clk,
   // Bench controls
   input  wire logic       tick_on,
   input  wire logic [5:0] levels,
   // Sources toward the block
   output logic [5:0]      src,
   output logic            ser_tick
);
   logic phase;

   initial begin
      phase    = 1'b0;
      ser_tick = 1'b0;
      src      = 6'h00;
   end

   // One bit tick every second cycle, driven off the sampling edge
   always @(negedge clk) begin
      phase    <= ~phase;
      ser_tick <= tick_on & phase;
      src      <= levels;
   end
endmodule : rom_src_model

// ### verif/rom_out_mux_bench.sv
// Self-checking bench for the output mux and divider override block.
// Assumes the source model and a two-bit serializer word for speed.
`timescale 1ns/1ps
module rom_out_mux_bench;
   logic                  clk, reset, sig_det_raw, cdr_lock_raw, tick_on, ser_tick;
   logic                  ser_out, out_driver_en, chan_power_en, prbs_enable;
   logic                  qclk_enable, research_disable;
   logic [2:0]            auto_div, div_code, active_src;
   logic [4:0]            div_ratio;
   logic [5:0]            lv, src;
   logic [7:0]            reg_rdata;
   rom_pkg::rom_reg_req_t reg_req;
   int                    n_errors, n_checks;
   logic [7:0]            ra [6] = '{8'h09, 8'h14, 8'h18, 8'h1E, 8'h3F, 8'h20};
   logic [7:0]            rv [6] = '{8'h00, 8'h00, 8'h00, 8'hE0, 8'h00, 8'h00};

   rom_src_model rom_src_model_inst (.clk(clk), .tick_on(tick_on), .levels(lv),
      .src(src), .ser_tick(ser_tick));

   rom_out_mux #(.WORD_BITS(2)) rom_out_mux_inst (.clk(clk), .reset(reset),
      .reg_req(reg_req), .reg_rdata(reg_rdata), .sig_det_raw(sig_det_raw),
      .cdr_lock_raw(cdr_lock_raw), .auto_div(auto_div), .raw_data(src[0]),
      .retimed_data(src[1]), .in_phase_oscillator_clock(src[2]),
      .quadrature_oscillator_clock(src[3]), .prbs_data(src[4]), .osc_10mhz(src[5]),
      .ser_tick(ser_tick), .ser_out(ser_out), .out_driver_en(out_driver_en),
      .chan_power_en(chan_power_en), .prbs_enable(prbs_enable),
      .qclk_enable(qclk_enable), .research_disable(research_disable),
      .div_ratio(div_ratio), .div_code(div_code), .active_src(active_src));

   // Clock
   initial clk = 1'b0;
   always #10 clk = ~clk;

   // -----------------------------------------------------------------
   // Tasks
   // -----------------------------------------------------------------
   task automatic summarize();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : summarize

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge clk);
      reg_req.wr = 1'b0;
      @(negedge clk);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge clk);
      reg_req.rd = 1'b0;
      @(negedge clk);
      chk(reg_rdata, exp);
   endtask : rd

   // Bounded wait on active source (sel 0) or channel power (sel 1)
   task automatic wait_on(input int sel, input logic [7:0] exp);
      int i;
      logic [7:0] v;
      for (i = 0; i < 60; i++) begin
         v = sel ? {7'h00, chan_power_en} : {5'h00, active_src};
         if (v === exp) break;
         @(negedge clk);
      end
      if (i == 60) begin
         n_errors++;
         summarize();
      end else begin
         chk(v, exp);
      end
   endtask : wait_on

   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial begin
      n_errors = 0;
      n_checks = 0;
      reset = 1'b1;
      sig_det_raw = 1'b0;
      cdr_lock_raw = 1'b0;
      auto_div = 3'h0;
      tick_on = 1'b1;
      lv = 6'h00;
      reg_req = '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 8'h00};
      repeat (2) @(posedge clk);
      @(negedge clk);
      reset = 1'b0;
      for (int k = 0; k < 6; k++) rd(ra[k], rv[k]);
      chk({5'h00, active_src}, 8'h07);
      chk({6'h00, chan_power_en, out_driver_en}, 8'h00);
      chk({7'h00, ser_out}, 8'h00);
      // Signal present, not locked, default field keeps mute
      sig_det_raw = 1'b1;
      lv = 6'h02;
      repeat (6) @(negedge clk);
      wait_on(1, 8'h01);
      chk({5'h00, active_src}, 8'h07);
      wr(8'h1E, 8'h00);
      wait_on(0, 8'h00);
      cdr_lock_raw = 1'b1;
      wait_on(0, 8'h01);
      repeat (6) @(negedge clk);
      chk({7'h00, ser_out}, 8'h01);
      // Override: every code but 6, locked then unlocked
      wr(8'h09, 8'h30);
      chk({7'h00, qclk_enable}, 8'h01);
      for (int p = 0; p < 2; p++) begin
         cdr_lock_raw = (p == 0);
         lv = p ? 6'h15 : 6'h2A;
         repeat (6) @(negedge clk);
         for (int c = 0; c < 8; c++) begin
            if (c == 6) continue;
            wr(8'h1E, {c[2:0], 5'h11});
            wait_on(0, c[7:0]);
            repeat (6) @(negedge clk);
            chk({7'h00, ser_out}, (c == 7) ? 8'h00 : {7'h00, lv[c]});
            chk({7'h00, out_driver_en}, (c == 7) ? 8'h00 : 8'h01);
         end
      end
      wr(8'h1E, 8'hD1);
      rd(8'h1E, 8'hF1);
      chk({5'h00, active_src}, 8'h07);
      // Quadrature and PRBS sources need their enables
      lv = 6'h3F;
      wr(8'h09, 8'h20);
      wr(8'h1E, 8'h61);
      wait_on(0, 8'h03);
      repeat (6) @(negedge clk);
      chk({6'h00, qclk_enable, ser_out}, 8'h00);
      wr(8'h1E, 8'h80);
      wait_on(0, 8'h04);
      repeat (6) @(negedge clk);
      chk({6'h00, prbs_enable, ser_out}, 8'h00);
      wr(8'h1E, 8'h90);
      repeat (6) @(negedge clk);
      chk({6'h00, prbs_enable, ser_out}, 8'h03);
      // No word boundary, no switch
      tick_on = 1'b0;
      wr(8'h1E, 8'h20);
      repeat (10) @(negedge clk);
      chk({5'h00, active_src}, 8'h04);
      tick_on = 1'b1;
      wait_on(0, 8'h01);
      // Clearing the override register returns to default
      wr(8'h1E, 8'h80);
      wait_on(0, 8'h04);
      cdr_lock_raw = 1'b1;
      repeat (6) @(negedge clk);
      wr(8'h09, 8'h00);
      wait_on(0, 8'h01);
      rd(8'h09, 8'h00);
      // Signal detect loss and forcing
      sig_det_raw = 1'b0;
      wait_on(1, 8'h00);
      wait_on(0, 8'h07);
      wr(8'h14, 8'h80);
      wait_on(1, 8'h01);
      rd(8'h14, 8'h80);
      wr(8'h14, 8'h00);
      wait_on(1, 8'h00);
      // Automatic then overridden divider
      for (int k = 0; k < 5; k++) begin
         auto_div = k[2:0];
         repeat (3) @(negedge clk);
         chk({div_ratio, div_code}, {5'h01 << k, k[2:0]});
      end
      auto_div = 3'h5;
      repeat (3) @(negedge clk);
      chk({5'h00, div_code}, 8'h04);
      wr(8'h09, 8'h04);
      auto_div = 3'h2;
      for (int k = 0; k < 5; k++) begin
         wr(8'h18, {1'b0, k[2:0], 4'h0});
         repeat (3) @(negedge clk);
         chk({div_ratio, div_code}, {5'h01 << k, k[2:0]});
      end
      wr(8'h18, 8'h50);
      rd(8'h18, 8'h40);
      wr(8'h3F, 8'h80);
      rd(8'h3F, 8'h80);
      chk({7'h00, research_disable}, 8'h01);
      summarize();
   end
endmodule : rom_out_mux_bench
